// ---- design/irq_priority_power_wake_ctrl.sv ----
// Interrupt controller with idle, stop and wakeup control
// ***********************************************************************
// Summary of operation
// ***********************************************************************
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
`include "irq_pwr_defines.svh"
module irq_priority_power_wake_ctrl
   import irq_pwr_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic ext_irq0,
   input wire logic ext_irq1,
   input wire logic [5:0] port0,
   input wire logic port3_bit2,
   input wire logic reset_pin_sel,
   input wire logic timer0_evt,
   input wire logic timer1_evt,
   input wire logic timer2_evt,
   input wire logic serial_tx_evt,
   input wire logic serial_rx_evt,
   input wire logic conv_window_evt,
   input wire logic conv_done_evt,
   input wire logic current_cmp_evt,
   input wire logic voltage_cmp_evt,
   input wire logic insn_boundary,
   input wire logic irq_ack,
   input wire logic return_from_irq,
   input wire logic external_move,
   output logic irq_req,
   output logic [7:0] irq_vector,
   output logic core_clk_en,
   output logic periph_clk_en,
   output logic wake_reset,
   output logic prog_write_gate
);
   // ***********************************************************************
   // Register state
   // ***********************************************************************
   byte_t power_config_q, wakeup_enable_q, interrupt_priority_q, extra_irq_priority_q;
   byte_t irq_enable_reg_q, extended_enable_reg_q, core_flags_q, serial_q, t2_q;
   byte_t extended_flag_reg_q, cmp_q, adc_control_q;
   logic [1:0] key_stage_q;
   logic [5:0] port0_q;
   logic [1:0] stack_q;
   pmode_e mode_q;
   reg_req_s bus;
   pick_s pick;
   logic x0_evt, x1_evt, key_evt, wr_ok_wk, stop_wake_irq, stop_wake_pin;
   logic [7:0] src_flag, src_en, src_req, prio_high;
   logic [7:0] src_hw_clear;

   assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   function automatic logic wr_to(input reg_req_s b, input logic [7:0] a);
      return b.wr && (b.addr == a);
   endfunction

   // ***********************************************************************
   // Event detection
   // ***********************************************************************
   ext_pin_detect u_x0 (
      .core_clk(core_clk), .rst_b(rst_b), .pin(ext_irq0),
      .edge_mode(core_flags_q[0]), .event_p(x0_evt)
   );
   ext_pin_detect u_x1 (
      .core_clk(core_clk), .rst_b(rst_b), .pin(ext_irq1),
      .edge_mode(core_flags_q[2]), .event_p(x1_evt)
   );

   // Port0 snapshot from the previous cycle; any change on port0 raises the key event
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         port0_q <= 6'h00;
      end else begin
         port0_q <= port0;
      end
   end
   assign key_evt = |(port0_q ^ port0);

   // ***********************************************************************
   // Source gathering: flags, enables, levels
   // ***********************************************************************
   assign src_flag = {extended_flag_reg_q[7] | cmp_q[2] | cmp_q[1],
                      adc_control_q[7] | adc_control_q[6], t2_q[0],
                      serial_q[1] | serial_q[0], core_flags_q[7], core_flags_q[3],
                      core_flags_q[5], core_flags_q[1]};
   // Shared slots: any enabled member requests its vector
   assign src_en = {extended_enable_reg_q[7] | cmp_q[0],
                    adc_control_q[4] | adc_control_q[3],
                    irq_enable_reg_q[5:0]};
   assign prio_high = {extra_irq_priority_q[`BIP_CMPKEY_BIT],
                       extra_irq_priority_q[`BIP_ADC_BIT],
                       interrupt_priority_q[5:0]};
   assign src_req = src_flag & src_en &
                    {8{irq_enable_reg_q[`IE_GLOBAL_BIT]}};

   irq_arbiter u_arb (
      .req(src_req), .prio_high(prio_high), .hi_active(stack_q[1]),
      .lo_active(stack_q[0]), .pick(pick)
   );

   // Hardware-cleared flags on acknowledge of their own vector
   assign src_hw_clear = (irq_ack && irq_req) ? (8'h01 << irq_vector[5:3]) : 8'h00;

   // ***********************************************************************
   // Key-protected access
   // ***********************************************************************
   // Two codes in order arm one write; any other key write disarms
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         key_stage_q <= 2'h0;
      end else if (wr_to(bus, `ADDR_ACCESS_KEY)) begin
         if (bus.wdata == `KEY_CODE_FIRST) begin
            key_stage_q <= 2'h1;
         end else if (bus.wdata == `KEY_CODE_SECOND && key_stage_q == 2'h1) begin
            key_stage_q <= 2'h2;
         end else begin
            key_stage_q <= 2'h0;
         end
      end else if (wr_to(bus, `ADDR_WAKEUP_ENABLE)) begin
         key_stage_q <= 2'h0;
      end
   end
   assign wr_ok_wk = wr_to(bus, `ADDR_WAKEUP_ENABLE) && key_stage_q == 2'h2;

   // ***********************************************************************
   // Configuration registers
   // ***********************************************************************
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wakeup_enable_q <= `RST_WAKEUP_ENABLE;
         interrupt_priority_q <= `RST_ZERO;
         extra_irq_priority_q <= `RST_ZERO;
         irq_enable_reg_q <= `RST_ZERO;
         extended_enable_reg_q <= `RST_ZERO;
      end else begin
         if (wr_ok_wk) wakeup_enable_q <= bus.wdata;
         if (wr_to(bus, `ADDR_IRQ_PRIORITY)) interrupt_priority_q <= bus.wdata;
         if (wr_to(bus, `ADDR_EXTRA_PRIORITY)) extra_irq_priority_q <= bus.wdata;
         if (wr_to(bus, `ADDR_IRQ_ENABLE)) irq_enable_reg_q <= bus.wdata;
         if (wr_to(bus, `ADDR_EXT_ENABLE)) extended_enable_reg_q <= bus.wdata;
      end
   end

   // ***********************************************************************
   // Flags: event set wins over any clear in the same cycle
   // ***********************************************************************
   // Clocked sources are frozen in stop since their clock is gone
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         core_flags_q <= `RST_ZERO;
         serial_q <= `RST_ZERO;
         t2_q <= `RST_ZERO;
      end else begin
         if (wr_to(bus, `ADDR_CORE_FLAGS)) core_flags_q <= bus.wdata;
         if (src_hw_clear[0]) core_flags_q[1] <= 1'b0;
         if (src_hw_clear[1]) core_flags_q[5] <= 1'b0;
         if (src_hw_clear[2]) core_flags_q[3] <= 1'b0;
         if (src_hw_clear[3]) core_flags_q[7] <= 1'b0;
         if (x0_evt) core_flags_q[1] <= 1'b1;
         if (x1_evt) core_flags_q[3] <= 1'b1;
         if (mode_q != pm_stop) begin
            if (timer0_evt) core_flags_q[5] <= 1'b1;
            if (timer1_evt) core_flags_q[7] <= 1'b1;
         end
         if (wr_to(bus, `ADDR_SERIAL_FLAGS)) serial_q <= bus.wdata;
         if (mode_q != pm_stop && serial_tx_evt) serial_q[1] <= 1'b1;
         if (mode_q != pm_stop && serial_rx_evt) serial_q[0] <= 1'b1;
         if (wr_to(bus, `ADDR_TIMER2_FLAG)) t2_q <= bus.wdata;
         if (mode_q != pm_stop && timer2_evt) t2_q[0] <= 1'b1;
      end
   end

   // Extra-source flags, cleared by software writing zero
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         extended_flag_reg_q <= `RST_ZERO;
         cmp_q <= `RST_ZERO;
         adc_control_q <= `RST_ZERO;
      end else begin
         if (wr_to(bus, `ADDR_EXT_FLAG)) extended_flag_reg_q <= bus.wdata;
         if (wr_to(bus, `ADDR_CMP_IRQ_CTRL)) cmp_q <= bus.wdata;
         if (wr_to(bus, `ADDR_ADC_CONTROL)) adc_control_q <= bus.wdata;
         if (key_evt) extended_flag_reg_q[7] <= 1'b1;
         if (mode_q != pm_stop) begin
            if (current_cmp_evt) cmp_q[2] <= 1'b1;
            if (voltage_cmp_evt) cmp_q[1] <= 1'b1;
            if (conv_window_evt) adc_control_q[7] <= 1'b1;
            if (conv_done_evt) adc_control_q[6] <= 1'b1;
         end
      end
   end

   // ***********************************************************************
   // Power modes
   // ***********************************************************************
   assign stop_wake_irq = (x0_evt & wakeup_enable_q[`WK_X0_BIT]) |
                          (x1_evt & wakeup_enable_q[`WK_X1_BIT]) |
                          (key_evt & wakeup_enable_q[`WK_KEY_BIT]);
   assign stop_wake_pin = !reset_pin_sel && port3_bit2;

   // Power config; stop and idle bits drop on wakeup
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         power_config_q <= `RST_ZERO;
      end else if (wr_to(bus, `ADDR_POWER_CONFIG)) begin
         power_config_q <= bus.wdata;
      end else if (mode_q == pm_stop && (stop_wake_irq || stop_wake_pin)) begin
         power_config_q[`PC_STOP_BIT] <= 1'b0;
      end else if (mode_q == pm_idle && pick.valid) begin
         power_config_q[`PC_IDLE_BIT] <= 1'b0;
      end
   end

   // Mode machine; stop overrides idle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_q <= pm_run;
      end else begin
         case (mode_q)
            pm_run: begin
               if (wr_to(bus, `ADDR_POWER_CONFIG) && bus.wdata[`PC_STOP_BIT]) begin
                  mode_q <= pm_stop;
               end else if (wr_to(bus, `ADDR_POWER_CONFIG) && bus.wdata[`PC_IDLE_BIT]) begin
                  mode_q <= pm_idle;
               end
            end
            pm_idle: if (pick.valid) mode_q <= pm_run;
            pm_stop: if (stop_wake_irq || stop_wake_pin) mode_q <= pm_run;
            default: mode_q <= pm_run;
         endcase
      end
   end

   // Clock gates and the wake-to-reset request, all registered
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         core_clk_en <= 1'b1;
         periph_clk_en <= 1'b1;
         wake_reset <= 1'b0;
      end else begin
         core_clk_en <= 1'b1;
         periph_clk_en <= 1'b1;
         wake_reset <= 1'b0;
         if (wr_to(bus, `ADDR_POWER_CONFIG) && bus.wdata[`PC_STOP_BIT]) begin
            core_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
         end else if (wr_to(bus, `ADDR_POWER_CONFIG) && bus.wdata[`PC_IDLE_BIT]) begin
            core_clk_en <= 1'b0;
         end else if (mode_q == pm_stop && !(stop_wake_irq || stop_wake_pin)) begin
            core_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
         end else if (mode_q == pm_idle && !pick.valid) begin
            core_clk_en <= 1'b0;
         end
         if (mode_q == pm_stop && (stop_wake_pin ||
             (stop_wake_irq && power_config_q[`PC_WAKE_RST_BIT]))) begin
            wake_reset <= 1'b1;
         end
      end
   end

   // Flash write gate during external moves
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prog_write_gate <= 1'b0;
      end else begin
         prog_write_gate <= external_move & power_config_q[`PC_PWE_BIT];
      end
   end

   // ***********************************************************************
   // Service: request, vector, active-level stack
   // ***********************************************************************
   // Offered at instruction boundaries or while idle or stopped; core pushes the pc on acknowledge
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_req <= 1'b0;
         irq_vector <= `VEC_BASE;
      end else if (irq_ack && irq_req) begin
         irq_req <= 1'b0;
      end else if (insn_boundary || mode_q != pm_run) begin
         irq_req <= pick.valid;
         irq_vector <= `VEC_BASE + {2'h0, pick.index, 3'h0};
      end
   end

   // Tracks active high and low routines; return pops the innermost
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         stack_q <= 2'h0;
      end else if (irq_ack && irq_req) begin
         if (prio_high[irq_vector[5:3]]) stack_q[1] <= 1'b1;
         else stack_q[0] <= 1'b1;
      end else if (return_from_irq) begin
         if (stack_q[1]) stack_q[1] <= 1'b0;
         else stack_q[0] <= 1'b0;
      end
   end

   // ***********************************************************************
   // Read port: data one cycle after the strobe, unmapped reads zero
   // ***********************************************************************
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (bus.rd) begin
         case (bus.addr)
            `ADDR_POWER_CONFIG: reg_rdata <= power_config_q;
            `ADDR_CORE_FLAGS: reg_rdata <= core_flags_q;
            `ADDR_EXT_FLAG: reg_rdata <= extended_flag_reg_q;
            `ADDR_SERIAL_FLAGS: reg_rdata <= serial_q;
            `ADDR_IRQ_ENABLE: reg_rdata <= irq_enable_reg_q;
            `ADDR_WAKEUP_ENABLE: reg_rdata <= wakeup_enable_q;
            `ADDR_IRQ_PRIORITY: reg_rdata <= interrupt_priority_q;
            `ADDR_EXTRA_PRIORITY: reg_rdata <= extra_irq_priority_q;
            `ADDR_CMP_IRQ_CTRL: reg_rdata <= cmp_q;
            `ADDR_TIMER2_FLAG: reg_rdata <= t2_q;
            `ADDR_EXT_ENABLE: reg_rdata <= extended_enable_reg_q;
            `ADDR_ADC_CONTROL: reg_rdata <= adc_control_q;
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule // irq_priority_power_wake_ctrl

// ---- inc/irq_pwr_defines.svh ----
// Register offsets, field positions, reset values and vector constants
`ifndef IRQ_PWR_DEFINES_SVH
`define IRQ_PWR_DEFINES_SVH
`define ADDR_POWER_CONFIG 8'h87
`define ADDR_CORE_FLAGS 8'h88
`define ADDR_EXT_FLAG 8'h91
`define ADDR_SERIAL_FLAGS 8'h98
`define ADDR_IRQ_ENABLE 8'ha8
`define ADDR_WAKEUP_ENABLE 8'hb6
`define ADDR_IRQ_PRIORITY 8'hb8
`define ADDR_EXTRA_PRIORITY 8'hb9
`define ADDR_CMP_IRQ_CTRL 8'hba
`define ADDR_TIMER2_FLAG 8'hc9
`define ADDR_EXT_ENABLE 8'he8
`define ADDR_ACCESS_KEY 8'heb
`define ADDR_ADC_CONTROL 8'hf1
`define RST_WAKEUP_ENABLE 8'h83
`define RST_ZERO 8'h00
`define KEY_CODE_FIRST 8'haf
`define KEY_CODE_SECOND 8'h50
`define PC_IDLE_BIT 5
`define PC_PWE_BIT 4
`define PC_WAKE_RST_BIT 3
`define PC_STOP_BIT 1
`define WK_KEY_BIT 7
`define WK_X1_BIT 1
`define WK_X0_BIT 0
`define IE_GLOBAL_BIT 7
`define BIP_CMPKEY_BIT 1
`define BIP_ADC_BIT 0
`define NUM_SRC 8
`define VEC_BASE 8'h03
`define VEC_STEP 8'h08
`endif

// ---- inc/irq_pwr_pkg.sv ----
// Types shared by the interrupt and power controller
package irq_pwr_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic [1:0] {pm_run, pm_idle, pm_stop} pmode_e;
   typedef struct packed {
      logic valid;
      logic [2:0] index;
      logic high;
   } pick_s;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;
endpackage

// ---- design/irq_arbiter.sv ----
// Two-level fixed-order arbiter for the eight interrupt vectors
`timescale 1ns/1ns
module irq_arbiter
   import irq_pwr_pkg::*;
(
   input wire logic [7:0] req,
   input wire logic [7:0] prio_high,
   input wire logic hi_active,
   input wire logic lo_active,
   output pick_s pick
);
   // Lowest index wins within a level
   function automatic pick_s first_of(input logic [7:0] v, input logic hi);
      pick_s p;
      p = '0;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) begin
            p.valid = 1'b1;
            p.index = 3'(i);
            p.high = hi;
         end
      end
      return p;
   endfunction

   // High level first; nothing nests under a high routine
   always_comb begin
      pick_s h;
      pick_s l;
      h = first_of(req & prio_high, 1'b1);
      l = first_of(req & ~prio_high, 1'b0);
      pick = '0;
      if (h.valid && !hi_active) begin
         pick = h;
      end else if (l.valid && !hi_active && !lo_active) begin
         pick = l;
      end
   end
endmodule // irq_arbiter

// ---- design/ext_pin_detect.sv ----
// Level or falling-edge detector for one external interrupt pin
`timescale 1ns/1ns
module ext_pin_detect (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic pin,
   input wire logic edge_mode,
   output logic event_p
);
   logic last_q;

   // Previous pin level for edge finding
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         last_q <= 1'b1;
      end else begin
         last_q <= pin;
      end
   end

   // Edge mode fires once per fall; level mode while low
   assign event_p = edge_mode ? (last_q & ~pin) : ~pin;
endmodule // ext_pin_detect

// ---- sim/irq_ctrl_properties.sv ----
// Port-level assertions for the interrupt and power controller
`timescale 1ns/1ns
`include "irq_pwr_defines.svh"
module irq_ctrl_checker (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic insn_boundary,
   input wire logic irq_ack,
   input wire logic external_move,
   input wire logic irq_req,
   input wire logic [7:0] irq_vector,
   input wire logic core_clk_en,
   input wire logic periph_clk_en,
   input wire logic wake_reset,
   input wire logic prog_write_gate
);
   logic pwe_q;
   // Shadow of the program-write bit, since the register is not visible at the ports
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pwe_q <= 1'b0;
      end else if (reg_wr && reg_addr == `ADDR_POWER_CONFIG) begin
         pwe_q <= reg_wdata[`PC_PWE_BIT];
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // Steps of a power mode entry and of an interrupt offer
   sequence s_stop_wr;
      reg_wr && reg_addr == `ADDR_POWER_CONFIG && reg_wdata[`PC_STOP_BIT];
   endsequence
   sequence s_idle_wr;
      reg_wr && reg_addr == `ADDR_POWER_CONFIG && reg_wdata[5:1] == 5'h10;
   endsequence
   sequence s_offer;
      irq_req && !irq_ack;
   endsequence
   a_stop_gates: assert property (s_stop_wr |=> !core_clk_en && !periph_clk_en)
      else $error("stop write left a clock running");
   a_idle_core: assert property (s_idle_wr |=> !core_clk_en && periph_clk_en)
      else $error("idle write gave wrong clock enables");
   a_vec_form: assert property (
      irq_req |-> irq_vector[2:0] == 3'h3 && irq_vector[7:6] == 2'h0)
      else $error("vector off the table");
   a_req_hold: assert property (s_offer |=> irq_req && $stable(irq_vector))
      else $error("offer dropped or changed before acknowledge");
   a_req_drop: assert property (irq_req && irq_ack |=> !irq_req)
      else $error("offer stayed after acknowledge");
   a_req_boundary: assert property (
      $rose(irq_req) |-> $past(insn_boundary) || !$past(core_clk_en))
      else $error("offer raised off a boundary");
   a_pwe_gate: assert property (prog_write_gate == $past(external_move && pwe_q))
      else $error("program write gate wrong");
   a_wake_pulse: assert property (wake_reset |=> !wake_reset)
      else $error("wake reset longer than one cycle");
   a_wake_clk: assert property (wake_reset |-> core_clk_en && periph_clk_en)
      else $error("wake reset while clocks stopped");
endmodule // irq_ctrl_checker
bind irq_priority_power_wake_ctrl irq_ctrl_checker i_chk (
   .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .insn_boundary(insn_boundary), .irq_ack(irq_ack),
   .external_move(external_move), .irq_req(irq_req), .irq_vector(irq_vector),
   .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en), .wake_reset(wake_reset),
   .prog_write_gate(prog_write_gate));

// ---- sim/core_model.sv ----
// Behavioural processor core: boundaries, vector acknowledge and return
`timescale 1ns/1ns
module core_model (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic core_clk_en,
   input wire logic irq_req,
   input wire logic [7:0] irq_vector,
   input wire logic ret_cmd,
   output logic insn_boundary,
   output logic irq_ack,
   output logic return_from_irq,
   output logic [7:0] last_vec,
   output logic [7:0] n_acks
);
   logic [1:0] step_q;
   // Boundary every third cycle; a gated core gives no boundary though its step count runs on
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         step_q <= 2'h0;
         insn_boundary <= 1'b0;
      end else begin
         step_q <= (step_q == 2'h2) ? 2'h0 : step_q + 2'h1;
         insn_boundary <= core_clk_en && step_q == 2'h0;
      end
   end
   // Take an offer once, log its vector, and pass returns through
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_ack <= 1'b0;
         return_from_irq <= 1'b0;
         last_vec <= 8'h00;
         n_acks <= 8'h00;
      end else begin
         irq_ack <= irq_req && core_clk_en && !irq_ack;
         return_from_irq <= ret_cmd;
         if (irq_ack) begin
            last_vec <= irq_vector;
            n_acks <= n_acks + 8'h01;
         end
      end
   end
endmodule // core_model

// ---- sim/irq_priority_power_wake_ctrl_bench.sv ----
// Self-checking bench for the interrupt and power controller
`timescale 1ns/1ns
module irq_priority_power_wake_ctrl_bench;
   logic core_clk, rst_b, reg_wr, reg_rd, reset_pin_sel, port3_bit2, external_move, ret_cmd;
   logic irq_req, core_clk_en, periph_clk_en, wake_reset, prog_write_gate, wake_seen;
   logic insn_boundary, irq_ack, return_from_irq;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, irq_vector, last_vec, n_acks, n0;
   logic [4:0] ev;
   logic [3:0] aev;
   logic [1:0] pins;
   logic [5:0] port0;
   int bad_count, n_tests;
   irq_priority_power_wake_ctrl i_dut (.core_clk(core_clk), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ext_irq0(pins[0]), .ext_irq1(pins[1]), .port0(port0),
      .port3_bit2(port3_bit2), .reset_pin_sel(reset_pin_sel), .timer0_evt(ev[0]),
      .timer1_evt(ev[1]), .timer2_evt(ev[2]), .serial_tx_evt(ev[3]), .serial_rx_evt(ev[4]),
      .conv_window_evt(aev[0]), .conv_done_evt(aev[1]), .current_cmp_evt(aev[2]),
      .voltage_cmp_evt(aev[3]), .insn_boundary(insn_boundary), .irq_ack(irq_ack),
      .return_from_irq(return_from_irq), .external_move(external_move), .irq_req(irq_req),
      .irq_vector(irq_vector), .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
      .wake_reset(wake_reset), .prog_write_gate(prog_write_gate));
   core_model i_core (.core_clk(core_clk), .rst_b(rst_b), .core_clk_en(core_clk_en),
      .irq_req(irq_req), .irq_vector(irq_vector), .ret_cmd(ret_cmd),
      .insn_boundary(insn_boundary), .irq_ack(irq_ack), .return_from_irq(return_from_irq),
      .last_vec(last_vec), .n_acks(n_acks));
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // Sticky copy of the one-cycle wake reset pulse
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_seen <= 1'b0;
      end else if (wake_reset === 1'b1) begin
         wake_seen <= 1'b1;
      end
   end
   // ************************************************************
   // Bus cycles and comparisons
   // ************************************************************
   task check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, exp);
   endtask
   // Events in m[4:0], falling pin pulses in m[6:5]
   task fire(input logic [6:0] m);
      @(posedge core_clk);
      ev <= m[4:0];
      pins <= ~m[6:5];
      @(posedge core_clk);
      ev <= 5'h00;
      pins <= 2'h3;
   endtask
   // Wait for one acknowledge, judge it, clear the flag by software, return
   task serve(input logic [7:0] vec, input logic [7:0] clr);
      n0 = n_acks;
      for (int i = 0; i < 300 && n_acks === n0; i++) @(posedge core_clk);
      check(last_vec, vec);
      check(n_acks - n0, 8'h01);
      wr(clr, 8'h00);
      ret_cmd <= 1'b1;
      @(posedge core_clk);
      ret_cmd <= 1'b0;
   endtask
   task wait_run;
      for (int i = 0; i < 60 && core_clk_en !== 1'b1; i++) @(posedge core_clk);
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   task t_regs;
      rd(8'hb6, 8'h83);
      rd(8'hb8, 8'h00);
      rd(8'h40, 8'h00);
      wr(8'hb6, 8'h00);
      rd(8'hb6, 8'h83);
      wr(8'heb, 8'haf);
      wr(8'heb, 8'h50);
      wr(8'hb6, 8'h81);
      rd(8'hb6, 8'h81);
      wr(8'hb9, 8'h03);
      rd(8'hb9, 8'h03);
      wr(8'hb9, 8'h00);
   endtask
   task t_disabled;
      wr(8'h88, 8'h05);
      wr(8'ha8, 8'h08);
      n0 = n_acks;
      fire(7'h02);
      repeat (20) @(posedge core_clk);
      check(n_acks, n0);
      rd(8'h88, 8'h85);
      wr(8'ha8, 8'h88);
      serve(8'h1b, 8'h40);
      rd(8'h88, 8'h05);
   endtask
   task t_order;
      wr(8'ha8, 8'hbf);
      fire(7'h1f);
      serve(8'h0b, 8'h40);
      serve(8'h1b, 8'h40);
      serve(8'h23, 8'h98);
      serve(8'h2b, 8'hc9);
      wr(8'hb8, 8'h20);
      fire(7'h24);
      serve(8'h2b, 8'hc9);
      serve(8'h03, 8'h40);
      wr(8'hb8, 8'h00);
   endtask
   // Converter and comparator slots use their own enables; comparator slot raised high
   task t_extra;
      wr(8'hf1, 8'h08);
      wr(8'hba, 8'h01);
      wr(8'hb9, 8'h02);
      @(posedge core_clk);
      aev <= 4'hf;
      @(posedge core_clk);
      aev <= 4'h0;
      serve(8'h3b, 8'hba);
      serve(8'h33, 8'hf1);
      wr(8'hb9, 8'h00);
   endtask
   task t_idle;
      wr(8'ha8, 8'h82);
      wr(8'h87, 8'h20);
      #1 check({6'h00, core_clk_en, periph_clk_en}, 8'h01);
      fire(7'h01);
      serve(8'h0b, 8'h40);
   endtask
   task t_stop;
      wr(8'he8, 8'h80);
      wr(8'h87, 8'h02);
      #1 check({6'h00, core_clk_en, periph_clk_en}, 8'h00);
      fire(7'h41);
      repeat (10) @(posedge core_clk);
      #1 check({6'h00, core_clk_en, periph_clk_en}, 8'h00);
      @(posedge core_clk);
      port0 <= 6'h04;
      wait_run();
      check({6'h00, core_clk_en, periph_clk_en}, 8'h03);
      serve(8'h3b, 8'h91);
      check({7'h00, wake_seen}, 8'h00);
   endtask
   task t_pwe;
      external_move <= 1'b1;
      wr(8'h87, 8'h10);
      @(posedge core_clk);
      #1 check({7'h00, prog_write_gate}, 8'h01);
      wr(8'h87, 8'h00);
      @(posedge core_clk);
      external_move <= 1'b0;
      #1 check({7'h00, prog_write_gate}, 8'h00);
   endtask
   task t_reset_pin;
      wr(8'h87, 8'h0a);
      reset_pin_sel <= 1'b0;
      port3_bit2 <= 1'b1;
      wait_run();
      repeat (3) @(posedge core_clk);
      check({6'h00, core_clk_en, wake_seen}, 8'h03);
      port3_bit2 <= 1'b0;
      reset_pin_sel <= 1'b1;
   endtask
   task complete_run;
      $display("mismatches %0d comparisons %0d", bad_count, n_tests);
      if (bad_count == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Watchdog well beyond the few hundred cycles the scenarios need
   initial begin
      #200000;
      bad_count++;
      complete_run();
   end
   initial begin
      {rst_b, reg_wr, reg_rd, external_move, ret_cmd, port3_bit2} = 6'h00;
      {reg_addr, reg_wdata, ev, aev, port0} = '0;
      pins = 2'h3;
      reset_pin_sel = 1'b1;
      bad_count = 0;
      n_tests = 0;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      t_regs();
      t_disabled();
      t_order();
      t_extra();
      t_idle();
      t_stop();
      t_pwe();
      t_reset_pin();
      complete_run();
   end
endmodule // irq_priority_power_wake_ctrl_bench
